// ===== rtl/mcj_decode.sv
/*
 conditional jump decoder for a solenoid microcore: control-register relative jump,
 feedback absolute and relative jumps, plus program counter update.
 assumes a one-word-per-cycle fetch: instr is valid with instr_valid and belongs
 to the address on core_program_counter; other opcodes step the pc.
 assumes the owner of the other jump kinds drives pc_load for them; a load wins
 over any decoded jump in the same cycle and clears both flags.
 assumes feedback_bus carries the comparators in feedback select order and that
 core_control_word is the executing core's own register, never the other core's.
*/
`timescale 1ns/100ps
`include "mcj_decode_map.svh"
module mcj_decode #(
	parameter int PC_W = 12,
	parameter int NUM_JREG = 2
) (
	input wire logic mclk, // core clock, 25 MHz
	input wire logic rst, // synchronous reset, active high
	input wire logic instr_valid, // instr holds a word to execute
	input wire logic [15:0] instr, // fetched instruction
	input wire logic [15:0] core_control_word, // this core's own control register
	input wire logic [15:0] feedback_bus, // feedback comparators, select order
	input wire logic [NUM_JREG*PC_W-1:0] jump_target_regs, // jump registers, 0 lowest
	input wire logic pc_load, // external load of the pc (other jumps)
	input wire logic [PC_W-1:0] pc_load_value, // value for pc_load
	output logic [PC_W-1:0] core_program_counter, // address of instr
	output logic jump_taken, // a decoded jump branched last cycle
	output logic jump_seen // a decoded jump executed last cycle
);
	localparam int OPC_W = `MCJ_OPC_HI - `MCJ_OPC_LO + 1;
	localparam int SEL_W = `MCJ_SEL_HI - `MCJ_SEL_LO + 1;
	localparam int TAIL_W = `MCJ_TAIL_HI - `MCJ_TAIL_LO + 1;
	localparam int DISP_W = `MCJ_DISP_HI - `MCJ_DISP_LO + 1;
	localparam int PC_MAX_W = $bits(mcj_decode_pkg::mcj_branch_t) - 2;
	localparam int HS_N = 5;
	localparam int LS_N = 6;

	// refuse widths and field maps that the datapath below cannot serve
	initial begin
		if (PC_W < DISP_W || PC_W > PC_MAX_W) begin
			$error("PC_W out of range");
		end
		if (NUM_JREG != 2) begin
			$error("jump register operand is one bit");
		end
		if (OPC_W != 6) begin
			$error("opcode field must be six bits");
		end
		if (SEL_W != 4) begin
			$error("select field must be four bits");
		end
		if (TAIL_W != 4) begin
			$error("tail field must be four bits");
		end
		if (DISP_W != 5) begin
			$error("displacement field must be five bits");
		end
		if (`MCJ_OPC_HI != 15) begin
			$error("opcode must sit at the top of the word");
		end
		if (`MCJ_TAIL_LO != 0 || `MCJ_DISP_LO != 0) begin
			$error("tail and displacement must start at bit zero");
		end
		if (`MCJ_SEL_LO <= `MCJ_POL_BIT) begin
			$error("select field overlaps polarity");
		end
		if (`MCJ_POL_BIT <= `MCJ_JREG_BIT) begin
			$error("polarity overlaps jump register select");
		end
		if (`MCJ_DISP_HI >= `MCJ_POL_BIT) begin
			$error("displacement overlaps polarity");
		end
		if (`MCJ_JREG_BIT <= `MCJ_TAIL_HI) begin
			$error("jump register select overlaps tail");
		end
		if (2 * HS_N + LS_N != 16) begin
			$error("feedback groups must fill the select range");
		end
		if (`MCJ_PC_STEP == 0) begin
			$error("pc step must advance");
		end
	end

	// field decode
	wire [5:0] opc = instr[`MCJ_OPC_HI:`MCJ_OPC_LO];
	wire [3:0] tail = instr[`MCJ_TAIL_HI:`MCJ_TAIL_LO];
	mcj_decode_pkg::mcj_fields_t fld;
	assign fld.sel = instr[`MCJ_SEL_HI:`MCJ_SEL_LO];
	assign fld.pol = instr[`MCJ_POL_BIT];
	assign fld.jreg = instr[`MCJ_JREG_BIT];
	assign fld.disp = instr[`MCJ_DISP_HI:`MCJ_DISP_LO];

	wire is_fb_abs = (opc == `MCJ_OPC_FB_ABS) && (tail == `MCJ_TAIL_FB_ABS);
	wire is_fb_rel = (opc == `MCJ_OPC_FB_REL);
	wire is_cr_rel = (opc == `MCJ_OPC_CR_REL);

	mcj_decode_pkg::mcj_kind_t kind;
	assign kind = !instr_valid ? mcj_decode_pkg::MCJ_NONE :
		is_fb_abs ? mcj_decode_pkg::MCJ_FB_ABS :
		is_fb_rel ? mcj_decode_pkg::MCJ_FB_REL :
		is_cr_rel ? mcj_decode_pkg::MCJ_CR_REL : mcj_decode_pkg::MCJ_NONE;

	// condition tests; control word is the executing core's own one
	wire cr_hit;
	wire fb_hit;
	mcj_cond_select #(.WIDTH(16)) u_cr_sel (
		.word(core_control_word),
		.sel(fld.sel),
		.pol(fld.pol),
		.hit(cr_hit)
	);
	// feedback codes: high-side drivers interleave drain and source on codes 0..9,
	// low-side drain feedback follows on codes 10..15; named groups keep it readable
	wire [HS_N-1:0] high_side_drain_fb;
	wire [HS_N-1:0] high_side_source_fb;
	wire [LS_N-1:0] low_side_drain_fb;
	wire [15:0] fb_ordered;

	for (genvar i = 0; i < HS_N; i++) begin : g_hs
		assign high_side_drain_fb[i] = feedback_bus[2*i];
		assign high_side_source_fb[i] = feedback_bus[2*i+1];
		assign fb_ordered[2*i] = high_side_drain_fb[i];
		assign fb_ordered[2*i+1] = high_side_source_fb[i];
	end

	for (genvar j = 0; j < LS_N; j++) begin : g_ls
		assign low_side_drain_fb[j] = feedback_bus[2*HS_N+j];
		assign fb_ordered[2*HS_N+j] = low_side_drain_fb[j];
	end

	mcj_cond_select #(.WIDTH(16)) u_fb_sel (
		.word(fb_ordered),
		.sel(fld.sel),
		.pol(fld.pol),
		.hit(fb_hit)
	);

	// relative target: own address plus sign-extended displacement;
	// the sum wraps modulo the pc width, so a backward jump past address 0 lands at the top
	wire [PC_W-1:0] disp_ext = PC_W'($signed(fld.disp));
	wire [PC_W-1:0] rel_target = core_program_counter + disp_ext;

	// jump register select is one bit, so NUM_JREG is pinned at two
	wire [PC_W-1:0] abs_target = jump_target_regs[fld.jreg*PC_W +: PC_W];

	// the step constant is 16 bits wide; only the low pc bits are kept on purpose
	wire [PC_W-1:0] seq_pc = PC_W'(core_program_counter + `MCJ_PC_STEP);

	mcj_decode_pkg::mcj_branch_t br;
	always_comb begin
		br.taken = 1'b0;
		br.is_jump = 1'b1;
		br.next_pc = 16'(seq_pc);
		case (kind)
			mcj_decode_pkg::MCJ_CR_REL: begin
				if (cr_hit) begin
					br.taken = 1'b1;
					br.next_pc = 16'(rel_target);
				end
			end
			mcj_decode_pkg::MCJ_FB_ABS: begin
				if (fb_hit) begin
					br.taken = 1'b1;
					br.next_pc = 16'(abs_target);
				end
			end
			mcj_decode_pkg::MCJ_FB_REL: begin
				if (fb_hit) begin
					br.taken = 1'b1;
					br.next_pc = 16'(rel_target);
				end
			end
			default: begin
				br.is_jump = 1'b0;
			end
		endcase
	end

	// external load has priority; wrap on overflow is intentional, code memory is circular
	wire [PC_W-1:0] pc_d = pc_load ? pc_load_value :
		instr_valid ? br.next_pc[PC_W-1:0] : core_program_counter;


	// flags describe the instruction just retired; a load discards that instruction
	wire taken_d = br.taken && !pc_load;
	wire seen_d = br.is_jump && !pc_load;

	always_ff @(posedge mclk) begin
		if (rst) begin
			core_program_counter <= PC_W'(`MCJ_PC_RST);
		end else begin
			core_program_counter <= pc_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			jump_taken <= 1'b0;
		end else begin
			jump_taken <= taken_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			jump_seen <= 1'b0;
		end else begin
			jump_seen <= seen_d;
		end
	end
endmodule

// ===== rtl/mcj_decode_map.svh
/*
 conditional jump decoder constants: opcodes, field positions, widths, reset values.
 assumes 16-bit instruction words and a program counter of up to 16 bits.
*/
//
// Operation
// - a relative control-register jump whose selected bit matches the polarity loads the pc with the relative target.
// - the displacement is a 5-bit two's complement field ranging from -16 to 15.
// - the relative target is the address of the jump instruction plus the sign-extended displacement.
// - the 4-bit control select field picks bit 0 to bit 15 of the 16-bit control word by its binary value.
// - the control word tested is the executing core's own control register (0x101, 0x102, 0x121, 0x122).
// - polarity 0 makes a 0 on the selected bit or feedback active, polarity 1 makes a 1 active.
// - an absolute feedback jump whose feedback matches takes the next address from the chosen jump register.
// - feedback codes 0 to 9 are high-side 1 to 5 drain then source, codes 10 to 15 are low-side 1 to 6 drain.
// - absolute feedback jump: bits 15:10 = 001110, select 9:6, polarity 5, jump register 4, bits 3:0 = 0100.
// - a relative feedback jump whose feedback matches loads the pc with the relative target.
// - relative feedback jump: bits 15:10 = 000101, select 9:6, polarity 5, displacement 4:0.
`ifndef MCJ_DECODE_MAP_SVH
`define MCJ_DECODE_MAP_SVH

`define MCJ_OPC_HI 15
`define MCJ_OPC_LO 10
`define MCJ_SEL_HI 9
`define MCJ_SEL_LO 6
`define MCJ_POL_BIT 5
`define MCJ_JREG_BIT 4
`define MCJ_TAIL_HI 3
`define MCJ_TAIL_LO 0
`define MCJ_DISP_HI 4
`define MCJ_DISP_LO 0

`define MCJ_OPC_FB_ABS 6'h0E
`define MCJ_TAIL_FB_ABS 4'h4
`define MCJ_OPC_FB_REL 6'h05
`define MCJ_OPC_CR_REL 6'h06

`define MCJ_PC_RST 16'h0000
`define MCJ_PC_STEP 16'h0001

`endif

// ===== rtl/mcj_decode_pkg.sv
/*
 types for the conditional jump decoder.
 assumes the map header is compiled alongside.
*/
package mcj_decode_pkg;
	typedef enum logic [3:0] {
		MCJ_NONE = 4'h1,
		MCJ_CR_REL = 4'h2,
		MCJ_FB_ABS = 4'h4,
		MCJ_FB_REL = 4'h8
	} mcj_kind_t;

	typedef struct packed {
		logic [3:0] sel;
		logic pol;
		logic jreg;
		logic [4:0] disp;
	} mcj_fields_t;

	typedef struct packed {
		logic taken;
		logic is_jump;
		logic [15:0] next_pc;
	} mcj_branch_t;
endpackage

// ===== rtl/mcj_cond_select.sv
/*
 condition selector: picks one bit of a word and tests it against a polarity.
 assumes the select value is within the word.
*/
`timescale 1ns/100ps
module mcj_cond_select #(
	parameter int WIDTH = 16
) (
	input wire logic [WIDTH-1:0] word, // candidate bits
	input wire logic [$clog2(WIDTH)-1:0] sel, // bit index
	input wire logic pol, // active level
	output logic hit // selected bit equals polarity
);
	initial begin
		if (WIDTH < 2) begin
			$error("WIDTH too small");
		end
	end

	wire picked = word[sel];
	assign hit = (picked == pol);
endmodule

// ===== verification/mcj_far_model.sv
/*
 far side of the jump decoder: control word, feedback comparators, jump registers.
 assumes the bench seeds the random source; values move every clock.
*/
`timescale 1ns/100ps
module mcj_far_model #(
	parameter int PC_W = 12
) (
	input wire logic mclk, // clock
	output logic [15:0] ctrl_word, // control register
	output logic [15:0] fb, // comparators
	output logic [2*PC_W-1:0] jregs // jump registers
);
	initial {ctrl_word, fb, jregs} = '0;
	// comparators move freely, so no stale value can pass for a match
	always @(posedge mclk) begin
		ctrl_word <= 16'($urandom);
		fb <= 16'($urandom);
		jregs <= (2*PC_W)'({$urandom, $urandom});
	end
endmodule

// ===== verification/mcj_decode_monitor.sv
/*
 port assertions for the jump decoder.
 assumes one clock and a synchronous reset.
*/
`timescale 1ns/100ps
module mcj_decode_monitor #(
	parameter int PC_W = 12,
	parameter int NUM_JREG = 2
) (
	input wire logic mclk, // clk
	input wire logic rst, // reset
	input wire logic instr_valid, // in
	input wire logic [15:0] instr, // in
	input wire logic [15:0] core_control_word, // in
	input wire logic [15:0] feedback_bus, // in
	input wire logic [NUM_JREG*PC_W-1:0] jump_target_regs, // in
	input wire logic pc_load, // in
	input wire logic [PC_W-1:0] pc_load_value, // in
	input wire logic [PC_W-1:0] core_program_counter, // out
	input wire logic jump_taken, // out
	input wire logic jump_seen // out
);
	wire logic go = instr_valid && !pc_load;
	wire logic [5:0] op = instr[15:10];
	wire logic hc = core_control_word[instr[9:6]] == instr[5];
	wire logic hf = feedback_bus[instr[9:6]] == instr[5];
	wire logic fa = op == 6'h0E && instr[3:0] == 4'h4;
	wire logic jk = op == 6'h06 || op == 6'h05 || fa;
	wire logic rt = op == 6'h06 && hc || op == 6'h05 && hf;
	wire logic [PC_W-1:0] nx = core_program_counter + 1'b1;
	wire logic [PC_W-1:0] rel = core_program_counter + PC_W'($signed(instr[4:0]));
	wire logic [PC_W-1:0] jr = jump_target_regs[instr[4]*PC_W +: PC_W];
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	property p_cr;
		go && op == 6'h06 && hc |=> jump_taken && core_program_counter == $past(rel);
	endproperty
	a_cr: assert property (p_cr) else $error("cr jump");
	property p_fbr;
		go && op == 6'h05 && hf |=> jump_taken && core_program_counter == $past(rel);
	endproperty
	a_fbr: assert property (p_fbr) else $error("fb rel jump");
	property p_fba;
		go && fa && hf |=> jump_taken && core_program_counter == $past(jr);
	endproperty
	a_fba: assert property (p_fba) else $error("fb abs jump");
	property p_span;
		go && rt |=> PC_W'(core_program_counter - $past(core_program_counter) + 5'h10) < 6'h20;
	endproperty
	a_span: assert property (p_span) else $error("span");
	property p_miss;
		go && jk && !(rt || fa && hf) |=> !jump_taken && core_program_counter == $past(nx);
	endproperty
	a_miss: assert property (p_miss) else $error("miss");
	property p_seen;
		go && jk |=> jump_seen;
	endproperty
	a_seen: assert property (p_seen) else $error("seen");
	property p_other;
		go && !jk |=> !jump_seen && core_program_counter == $past(nx);
	endproperty
	a_other: assert property (p_other) else $error("other");
	property p_rst;
		disable iff (1'b0) rst |=> core_program_counter == '0 && !jump_seen;
	endproperty
	a_rst: assert property (p_rst) else $error("reset");
	c_cr: cover property (go && op == 6'h06 && hc);
	c_fa: cover property (go && fa && hf);
	c_miss: cover property (jump_seen && !jump_taken);
endmodule

// ===== verification/mcj_decode_tb.sv
/*
 random bench for the jump decoder with range-end displacements.
 assumes the far model and the monitor are compiled first.
*/
`timescale 1ns/100ps
`include "mcj_decode_map.svh"
module mcj_decode_tb;
	localparam int W = 12;
	logic mclk, rst, instr_valid, pc_load, jump_taken, jump_seen, et, es;
	logic [15:0] instr, cw, fb;
	logic [2*W-1:0] jr;
	logic [W-1:0] ldv, pc, ep;
	int failures, n_checks;
	mcj_decode #(.PC_W(W), .NUM_JREG(2)) u_mcj_decode (.mclk, .rst, .instr_valid, .instr,
		.core_control_word(cw), .feedback_bus(fb), .jump_target_regs(jr), .pc_load,
		.pc_load_value(ldv), .core_program_counter(pc), .jump_taken, .jump_seen);
	mcj_far_model #(.PC_W(W)) u_mcj_far_model (.mclk, .ctrl_word(cw), .fb, .jregs(jr));
	function automatic logic [W+1:0] model(logic [W-1:0] p);
		logic hc;
		logic hf;
		logic [W-1:0] rp;
		logic [W-1:0] np;
		hc = cw[instr[9:6]] === instr[5];
		hf = fb[instr[9:6]] === instr[5];
		rp = p + W'($signed(instr[4:0]));
		np = p + 1'b1;
		if (pc_load)
			return {2'b00, ldv};
		if (!instr_valid)
			return {2'b00, p};
		case (instr[15:10])
			`MCJ_OPC_CR_REL: return {hc, 1'b1, hc ? rp : np};
			`MCJ_OPC_FB_REL: return {hf, 1'b1, hf ? rp : np};
			`MCJ_OPC_FB_ABS: if (instr[3:0] == `MCJ_TAIL_FB_ABS)
				return {hf, 1'b1, hf ? jr[instr[4]*W +: W] : np};
			default: ;
		endcase
		return {2'b00, np};
	endfunction
	task automatic drive();
		logic [15:0] w;
		w = 16'($urandom);
		if ($urandom % 4 == 0)
			w[4:0] = w[0] ? 5'h10 : 5'h0F;
		case ($urandom % 4)
			0: w[15:10] = `MCJ_OPC_CR_REL;
			1: w[15:10] = `MCJ_OPC_FB_REL;
			2: w = {`MCJ_OPC_FB_ABS, w[9:4], `MCJ_TAIL_FB_ABS};
			default: ;
		endcase
		instr <= w;
		instr_valid <= $urandom % 8 != 0;
		pc_load <= $urandom % 32 == 0;
		ldv <= W'($urandom);
	endtask
	task automatic complete_run();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	initial begin
		#40000;
		failures++;
		complete_run();
	end
	initial begin
		{failures, n_checks} = '0;
		{rst, instr_valid, pc_load, instr, ldv} = {3'h4, 16'h0000, W'(0)};
		void'($urandom(32'hE5727825));
		{et, es, ep} = '0;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		repeat (400) begin
			@(posedge mclk);
			n_checks++;
			if ({jump_taken, jump_seen, pc} !== {et, es, ep}) begin
				failures++;
				$display("wrong value at %0t: pc %h expected %h", $time, pc, ep);
			end
			{et, es, ep} = model(ep);
			drive();
		end
		complete_run();
	end
endmodule
bind mcj_decode mcj_decode_monitor #(.PC_W(PC_W), .NUM_JREG(NUM_JREG)) u_mcj_decode_monitor (
	.mclk, .rst, .instr_valid, .instr, .core_control_word, .feedback_bus, .jump_target_regs,
	.pc_load, .pc_load_value, .core_program_counter, .jump_taken, .jump_seen);
